// file: core/cmcp_pkg.sv
// Constants of the core memory controller: register map, fields, commands, timing.
// Assumes a 100 MHz clock; every time below is converted to clock cycles here.
package cmcp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_W = 48;
  localparam int RA_W = 6;
  localparam int CNT_W = 16;
  // Register offsets (byte addresses)
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_ADDR = 6'h04;
  localparam logic [5:0] OFF_WLO = 6'h08;
  localparam logic [5:0] OFF_WHI = 6'h0C;
  localparam logic [5:0] OFF_CMD = 6'h10;
  localparam logic [5:0] OFF_STAT = 6'h14;
  localparam logic [5:0] OFF_RLO = 6'h18;
  localparam logic [5:0] OFF_RHI = 6'h1C;
  localparam logic [5:0] OFF_AOUT = 6'h20;
  // Control register: bit 0 random access, bits 4:1 zone levels
  localparam int CTRL_W = 5;
  localparam int CTRL_RANDOM = 0;
  localparam int CTRL_ZONE_LSB = 1;
  localparam int ZONE_N = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;
  // Status register bits; sticky ones are cleared by writing 1
  localparam int ST_BUSY = 0;
  localparam int ST_MEM_BUSY = 1;
  localparam int ST_STK_LSB = 2;
  localparam int STK_N = 5;
  localparam int STK_DONE = 0;
  localparam int STK_RDY = 1;
  localparam int STK_REFUSED = 2;
  localparam int STK_TIMEOUT = 3;
  localparam int STK_RAIL = 4;
  localparam int ST_FLAG_LSB = 7;
  localparam int ST_RMW = 11;
  // Pulse pins, by index; command codes 0..15 fire the pulse of that index
  localparam int NPULSE = 16;
  localparam int P_REGEN = 0;
  localparam int P_OVERWRITE = 1;
  localparam int P_LOAD = 2;
  localparam int P_UNLOAD = 3;
  localparam int P_WIPE = 4;
  localparam int P_ACLR = 5;
  localparam int P_ASHIFT = 6;
  localparam int P_WPZERO = 7;
  localparam int P_RPZERO = 8;
  localparam int P_WPADV = 9;
  localparam int P_AADV = 10;
  localparam int P_ASTROBE = 11;
  localparam int P_WSTROBE = 12;
  localparam int P_WCLR = 13;
  localparam int P_WADV = 14;
  localparam int P_WSHIFT = 15;
  localparam logic [4:0] CMD_RMW_UNLOAD = 5'h10;
  localparam logic [4:0] CMD_RMW_LOAD = 5'h11;
  // Times in ns and derived cycle counts
  localparam int PULSE_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int WIPE_NS = 1500;
  localparam int SHIFT_NS = 1000;
  localparam int TIMEOUT_NS = 20000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WIPE_CYC = (WIPE_NS * CLK_MHZ + 999) / 1000;
  localparam int SHIFT_CYC = (SHIFT_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ) / 1000;
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_PULSE, S_WAIT, S_GAP} cmcp_state_type;
endpackage

// file: core/cmcp_host.sv
// Controller that drives a 48-bit core memory through its command pins.
// Assumes memory pins are asynchronous to CLK; software uses the plain register port.
// Overview of operation
// - Pin level 1 means ground, active pulse.
// - Issue regenerate-read or overwrite full cycles.
// - Same-address update: unload, pause, then load.
// - Hold update level from unload through load.
// - Present address as static levels.
// - Present write data on true/complement rails.
// - Static level selects random or counting addressing.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cmcp_host #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [cmcp_pkg::RA_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic MEM_REGEN_READ_CMD,
  output logic MEM_OVERWRITE_CMD,
  output logic MEM_LOAD_CMD,
  output logic MEM_UNLOAD_CMD,
  output logic MEM_CORE_WIPE_PULSE,
  output logic MEM_ADDR_REG_CLEAR,
  output logic MEM_ADDR_SHIFT_IN,
  output logic MEM_WRITE_PTR_ZERO,
  output logic MEM_READ_PTR_ZERO,
  output logic MEM_WRITE_PTR_ADVANCE,
  output logic MEM_ADDR_ADVANCE,
  output logic MEM_ADDR_LOAD_STROBE,
  output logic MEM_WORD_LOAD_STROBE,
  output logic MEM_WORD_REG_CLEAR,
  output logic MEM_WORD_REG_ADVANCE,
  output logic MEM_WORD_SHIFT,
  output logic MEM_ACCESS_KIND_LEVEL,
  output logic MEM_SAME_ADDR_UPDATE_LEVEL,
  output logic [cmcp_pkg::ZONE_N-1:0] MEM_ZONE_MODE_LEVELS,
  output logic [ADDR_W-1:0] MEM_ADDR_IN,
  output logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_IN_T,
  output logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_IN_F,
  input wire logic [ADDR_W-1:0] MEM_ADDR_REG_OUTPUTS,
  input wire logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_REG_OUTPUTS_T,
  input wire logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_REG_OUTPUTS_F,
  input wire logic MEM_CYCLE_DONE_PULSE,
  input wire logic MEM_CYCLE_IN_PROGRESS_N,
  input wire logic MEM_WORD_READY_PULSE,
  input wire logic MEM_DIRECT_ADDR_FLAG,
  input wire logic MEM_COUNTING_ADDR_FLAG,
  input wire logic MEM_LOAD_MODE,
  input wire logic MEM_UNLOAD_MODE
);
  import cmcp_pkg::*;

  // Maps a command code to its pulse pin
  function automatic logic [3:0] cmd_pulse(input logic [4:0] c);
    if (c == CMD_RMW_UNLOAD) begin
      return 4'(P_UNLOAD);
    end else if (c == CMD_RMW_LOAD) begin
      return 4'(P_LOAD);
    end
    return c[3:0];
  endfunction

  // Synchronisers; busy pin resets to its idle (high) level
  logic [6:0] in_s1_r, in_s2_r;
  logic [1:0] ed_r;
  logic [ADDR_W-1:0] ao_s1_r, ao_s2_r;
  logic [WORD_W-1:0] wt_s1_r, wt_s2_r, wf_s1_r, wf_s2_r;
  logic [6:0] in_raw;
  assign in_raw = {MEM_UNLOAD_MODE, MEM_LOAD_MODE, MEM_COUNTING_ADDR_FLAG,
                   MEM_DIRECT_ADDR_FLAG, MEM_WORD_READY_PULSE,
                   MEM_CYCLE_IN_PROGRESS_N, MEM_CYCLE_DONE_PULSE};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_s1_r <= 7'h02;
      in_s2_r <= 7'h02;
      ed_r <= 2'h0;
      ao_s1_r <= '0;
      ao_s2_r <= '0;
      wt_s1_r <= '0;
      wt_s2_r <= '0;
      wf_s1_r <= '0;
      wf_s2_r <= '0;
    end else begin
      in_s1_r <= in_raw;
      in_s2_r <= in_s1_r;
      ed_r <= {in_s2_r[2], in_s2_r[0]};
      ao_s1_r <= MEM_ADDR_REG_OUTPUTS;
      ao_s2_r <= ao_s1_r;
      wt_s1_r <= MEM_WORD_REG_OUTPUTS_T;
      wt_s2_r <= wt_s1_r;
      wf_s1_r <= MEM_WORD_REG_OUTPUTS_F;
      wf_s2_r <= wf_s1_r;
    end
  end

  logic ev_done, ev_rdy, mem_busy;
  assign ev_done = in_s2_r[0] && !ed_r[0];
  assign ev_rdy = in_s2_r[2] && !ed_r[1];
  assign mem_busy = !in_s2_r[1];

  cmcp_state_type st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [NPULSE-1:0] pls_r, pls_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic wt_r, wt_nxt, rmw_r, rmw_nxt, rmwld_r, rmwld_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [WORD_W-1:0] wdt_r, wdt_nxt, wdf_r, wdf_nxt, rword_r, rword_nxt;
  logic [STK_N-1:0] stk_r, stk_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic go, cyc, refuse, wr_ok;
  logic [4:0] c;
  logic [3:0] ci;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pls_nxt = pls_r;
    idx_nxt = idx_r;
    wt_nxt = wt_r;
    rmw_nxt = rmw_r;
    rmwld_nxt = rmwld_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    wdt_nxt = wdt_r;
    stk_nxt = stk_r;
    rword_nxt = rword_r;
    rdata_nxt = 32'h0;
    c = REG_WDATA[4:0];
    ci = cmd_pulse(c);
    go = REG_WR && (REG_ADDR == OFF_CMD);
    cyc = ci <= 4'(P_UNLOAD);
    // A cycle only starts when the memory is idle and the update sequence allows it
    refuse = (REG_WDATA[31:5] != 27'h0) || (c > CMD_RMW_LOAD)
      || (cyc && mem_busy)
      || (c == CMD_RMW_LOAD && !rmw_r) || (c == CMD_RMW_UNLOAD && rmw_r)
      || (rmw_r && c != CMD_RMW_LOAD && ci < 4'(P_WSTROBE));
    // Levels change only between operations so the memory sees them static
    wr_ok = (st_r == S_IDLE) && !rmw_r;
    if (REG_WR && (REG_ADDR == OFF_STAT)) begin
      stk_nxt = stk_r & ~REG_WDATA[ST_STK_LSB +: STK_N];
    end
    if (REG_WR && (REG_ADDR == OFF_CTRL || REG_ADDR == OFF_ADDR)) begin
      if (!wr_ok) begin
        stk_nxt[STK_REFUSED] = 1'b1;
      end else if (REG_ADDR == OFF_CTRL) begin
        ctrl_nxt = REG_WDATA[CTRL_W-1:0];
      end else begin
        addr_nxt = REG_WDATA[ADDR_W-1:0];
      end
    end
    if (REG_WR && (REG_ADDR == OFF_WLO || REG_ADDR == OFF_WHI)) begin
      if (st_r != S_IDLE) begin
        stk_nxt[STK_REFUSED] = 1'b1;
      end else if (REG_ADDR == OFF_WLO) begin
        wdt_nxt[31:0] = REG_WDATA;
      end else begin
        wdt_nxt[WORD_W-1:32] = REG_WDATA[WORD_W-33:0];
      end
    end
    unique case (st_r)
      S_IDLE: begin
        if (go && refuse) begin
          stk_nxt[STK_REFUSED] = 1'b1;
        end else if (go) begin
          st_nxt = S_LEAD;
          cnt_nxt = CNT_W'(SETUP_CYC - 1);
          idx_nxt = ci;
          wt_nxt = cyc;
          rmwld_nxt = (c == CMD_RMW_LOAD);
          if (c == CMD_RMW_UNLOAD) begin
            rmw_nxt = 1'b1;
          end
        end
      end
      S_LEAD: begin
        if (cnt_r == '0) begin
          pls_nxt = NPULSE'(1) << idx_r;
          cnt_nxt = (idx_r == 4'(P_WIPE)) ? CNT_W'(WIPE_CYC - 1) : CNT_W'(PULSE_CYC - 1);
          st_nxt = S_PULSE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_PULSE: begin
        if (cnt_r == '0) begin
          pls_nxt = '0;
          if (wt_r) begin
            st_nxt = S_WAIT;
            cnt_nxt = CNT_W'(TIMEOUT_CYC - 1);
          end else begin
            st_nxt = S_GAP;
            // Shifts are spaced to the memory's 1 MHz shift rate
            cnt_nxt = (idx_r == 4'(P_ASHIFT) || idx_r == 4'(P_WSHIFT))
              ? CNT_W'(SHIFT_CYC - PULSE_CYC - 1) : CNT_W'(PULSE_CYC - 1);
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_WAIT: begin
        if (ev_done || cnt_r == '0) begin
          st_nxt = S_GAP;
          cnt_nxt = CNT_W'(PULSE_CYC - 1);
          stk_nxt[STK_TIMEOUT] = stk_nxt[STK_TIMEOUT] | !ev_done;
          if (rmwld_r) begin
            rmw_nxt = 1'b0;
            rmwld_nxt = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_GAP: begin
        if (cnt_r == '0) begin
          st_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
    if (go && st_r != S_IDLE) begin
      stk_nxt[STK_REFUSED] = 1'b1;
    end
    if (ev_rdy) begin
      rword_nxt = wt_s2_r;
      stk_nxt[STK_RDY] = 1'b1;
      if (wt_s2_r != ~wf_s2_r) begin
        stk_nxt[STK_RAIL] = 1'b1;
      end
    end
    if (ev_done) begin
      stk_nxt[STK_DONE] = 1'b1;
    end
    wdf_nxt = ~wdt_nxt;
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_CTRL: rdata_nxt = 32'(ctrl_r);
        OFF_ADDR: rdata_nxt = 32'(addr_r);
        OFF_WLO: rdata_nxt = wdt_r[31:0];
        OFF_WHI: rdata_nxt = 32'(wdt_r[WORD_W-1:32]);
        OFF_STAT: begin
          rdata_nxt[ST_BUSY] = st_r != S_IDLE;
          rdata_nxt[ST_MEM_BUSY] = mem_busy;
          rdata_nxt[ST_STK_LSB +: STK_N] = stk_r;
          rdata_nxt[ST_FLAG_LSB +: 4] = in_s2_r[6:3];
          rdata_nxt[ST_RMW] = rmw_r;
        end
        OFF_RLO: rdata_nxt = rword_r[31:0];
        OFF_RHI: rdata_nxt = 32'(rword_r[WORD_W-1:32]);
        OFF_AOUT: rdata_nxt = 32'(ao_s2_r);
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= S_IDLE;
      cnt_r <= '0;
      pls_r <= '0;
      idx_r <= 4'h0;
      wt_r <= 1'b0;
      rmw_r <= 1'b0;
      rmwld_r <= 1'b0;
      ctrl_r <= CTRL_RST;
      addr_r <= '0;
      wdt_r <= '0;
      wdf_r <= '1;
      stk_r <= '0;
      rword_r <= '0;
      rdata_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pls_r <= pls_nxt;
      idx_r <= idx_nxt;
      wt_r <= wt_nxt;
      rmw_r <= rmw_nxt;
      rmwld_r <= rmwld_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      wdt_r <= wdt_nxt;
      wdf_r <= wdf_nxt;
      stk_r <= stk_nxt;
      rword_r <= rword_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // High on a pin stands for the ground level, the active sense of each pulse
  assign {MEM_WORD_SHIFT, MEM_WORD_REG_ADVANCE, MEM_WORD_REG_CLEAR, MEM_WORD_LOAD_STROBE,
          MEM_ADDR_LOAD_STROBE, MEM_ADDR_ADVANCE, MEM_WRITE_PTR_ADVANCE, MEM_READ_PTR_ZERO,
          MEM_WRITE_PTR_ZERO, MEM_ADDR_SHIFT_IN, MEM_ADDR_REG_CLEAR, MEM_CORE_WIPE_PULSE,
          MEM_UNLOAD_CMD, MEM_LOAD_CMD, MEM_OVERWRITE_CMD, MEM_REGEN_READ_CMD} = pls_r;
  assign MEM_ACCESS_KIND_LEVEL = ctrl_r[CTRL_RANDOM];
  assign MEM_ZONE_MODE_LEVELS = ctrl_r[CTRL_ZONE_LSB +: ZONE_N];
  assign MEM_SAME_ADDR_UPDATE_LEVEL = rmw_r;
  assign MEM_ADDR_IN = addr_r;
  assign MEM_WORD_IN_T = wdt_r;
  assign MEM_WORD_IN_F = wdf_r;
  assign REG_RDATA = rdata_r;

  localparam int PW_A = PULSE_CYC;
  localparam int WP_A = WIPE_CYC;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rise(int i);
    $rose(pls_r[i]);
  endsequence
  sequence s_busy_cycle_cmd;
    st_r == S_IDLE && REG_WR && REG_ADDR == OFF_CMD && mem_busy && REG_WDATA < 32'h4;
  endsequence

  one_pulse_a: assert property ($onehot0(pls_r))
    else $error("two pin pulses at once");
  regen_width_a: assert property (s_rise(P_REGEN) |-> ##PW_A $fell(pls_r[P_REGEN]))
    else $error("read cycle pulse width wrong");
  wipe_width_a: assert property (s_rise(P_WIPE) |-> ##WP_A $fell(pls_r[P_WIPE]))
    else $error("wipe pulse width wrong");
  busy_block_a: assert property (s_busy_cycle_cmd |=> st_r == S_IDLE && pls_r == '0)
    else $error("cycle started while memory busy");
  rmw_lead_a: assert property (s_rise(P_UNLOAD) ##0 rmw_r |-> $past(rmw_r, 2))
    else $error("update level not set ahead of unload");
  rmw_hold_a: assert property ($fell(rmw_r) |-> $past(rmwld_r) && $past(st_r) == S_WAIT)
    else $error("update level dropped before load cycle ended");
  addr_static_a: assert property (st_r != S_IDLE |=> $stable(addr_r))
    else $error("address changed during operation");
  kind_static_a: assert property (st_r != S_IDLE |=> $stable(ctrl_r))
    else $error("access kind changed during operation");
  rail_pair_a: assert property (MEM_WORD_IN_F == ~MEM_WORD_IN_T)
    else $error("data rails not complementary");
  done_wait_a: assert property (st_r == S_WAIT && ev_done |=> st_r == S_GAP && stk_r[STK_DONE])
    else $error("cycle end not taken");
  ready_capt_a: assert property (ev_rdy |=> rword_r == $past(wt_s2_r))
    else $error("ready word not captured");
endmodule // cmcp_host

// file: bench/cmcp_mem_model.sv
// Behavioural core memory facing the controller: address and word registers, core, cycles.
// Assumes the bench clock as its time base and active-high (ground level) pins.
`timescale 1ns/1ps
module cmcp_mem_model #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MEM_REGEN_READ_CMD,
  input wire logic MEM_OVERWRITE_CMD,
  input wire logic MEM_LOAD_CMD,
  input wire logic MEM_UNLOAD_CMD,
  input wire logic MEM_CORE_WIPE_PULSE,
  input wire logic MEM_ADDR_REG_CLEAR,
  input wire logic MEM_ADDR_ADVANCE,
  input wire logic MEM_ADDR_LOAD_STROBE,
  input wire logic MEM_WORD_LOAD_STROBE,
  input wire logic MEM_WORD_REG_CLEAR,
  input wire logic MEM_ACCESS_KIND_LEVEL,
  input wire logic [ADDR_W-1:0] MEM_ADDR_IN,
  input wire logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_IN_T,
  output logic [ADDR_W-1:0] MEM_ADDR_REG_OUTPUTS,
  output logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_REG_OUTPUTS_T,
  output logic [cmcp_pkg::WORD_W-1:0] MEM_WORD_REG_OUTPUTS_F,
  output logic MEM_CYCLE_DONE_PULSE,
  output logic MEM_CYCLE_IN_PROGRESS_N,
  output logic MEM_WORD_READY_PULSE,
  output logic MEM_DIRECT_ADDR_FLAG,
  output logic MEM_COUNTING_ADDR_FLAG,
  output logic MEM_LOAD_MODE,
  output logic MEM_UNLOAD_MODE
);
  import cmcp_pkg::*;
  logic [WORD_W-1:0] core [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] word_r;
  logic [ADDR_W-1:0] addr_r;
  logic [3:0] kind_r, cmd_d;
  logic [5:0] p_d;
  int t;
  wire logic [3:0] cmds = {MEM_LOAD_CMD, MEM_UNLOAD_CMD, MEM_OVERWRITE_CMD, MEM_REGEN_READ_CMD};
  wire logic [3:0] rc = cmds & ~cmd_d;
  wire logic [5:0] p = {MEM_CORE_WIPE_PULSE, MEM_WORD_REG_CLEAR, MEM_WORD_LOAD_STROBE,
                        MEM_ADDR_LOAD_STROBE, MEM_ADDR_ADVANCE, MEM_ADDR_REG_CLEAR};
  // Pins act on their rising edge only, so a long pulse counts once
  wire logic [5:0] e = p & ~p_d;
  assign MEM_ADDR_REG_OUTPUTS = addr_r;
  assign MEM_WORD_REG_OUTPUTS_T = word_r;
  assign MEM_WORD_REG_OUTPUTS_F = ~word_r;
  assign MEM_CYCLE_IN_PROGRESS_N = (t == 0);
  assign MEM_DIRECT_ADDR_FLAG = MEM_ACCESS_KIND_LEVEL;
  assign MEM_COUNTING_ADDR_FLAG = ~MEM_ACCESS_KIND_LEVEL;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= '0;
      word_r <= '0;
      kind_r <= '0;
      cmd_d <= '0;
      p_d <= '0;
      t <= 0;
      MEM_CYCLE_DONE_PULSE <= 1'b0;
      MEM_WORD_READY_PULSE <= 1'b0;
      MEM_LOAD_MODE <= 1'b0;
      MEM_UNLOAD_MODE <= 1'b0;
    end else begin
      cmd_d <= cmds;
      p_d <= p;
      if (e[0]) addr_r <= '0;
      else if (e[1]) addr_r <= addr_r + 1'b1;
      else if (e[2]) addr_r <= MEM_ADDR_IN;
      if (e[3]) word_r <= MEM_WORD_IN_T;
      else if (e[4]) word_r <= '0;
      if (e[5]) foreach (core[i]) core[i] <= '0;
      if (|rc && t == 0) begin
        t <= 1;
        kind_r <= rc;
        MEM_LOAD_MODE <= rc[3];
        MEM_UNLOAD_MODE <= rc[2];
      end else if (t != 0) t <= t + 1;
      if (t == 6 && (kind_r[0] || kind_r[2])) word_r <= core[addr_r];
      if (t == 6 && (kind_r[1] || kind_r[3])) begin
        word_r <= MEM_WORD_IN_T;
        core[addr_r] <= MEM_WORD_IN_T;
      end
      MEM_WORD_READY_PULSE <= (t == 8 || t == 9) && (kind_r[0] || kind_r[2]);
      MEM_CYCLE_DONE_PULSE <= (t >= 20 && t < 23);
      if (t == 23) t <= 0;
    end
  end
endmodule // cmcp_mem_model

// file: bench/cmcp_host_tb.sv
// Self-checking bench for the core memory controller, register port on one side.
// Assumes the behavioural memory model on the pin side; one 100 MHz clock.
`timescale 1ns/1ps
module cmcp_host_tb;
  import cmcp_pkg::*;
  localparam int ADDR_W = 12;
  logic CLK, RST_N, REG_WR, REG_RD;
  logic [RA_W-1:0] REG_ADDR;
  logic [31:0] REG_WDATA, d;
  wire logic [31:0] REG_RDATA;
  wire logic MEM_REGEN_READ_CMD, MEM_OVERWRITE_CMD, MEM_LOAD_CMD, MEM_UNLOAD_CMD;
  wire logic MEM_CORE_WIPE_PULSE, MEM_ADDR_REG_CLEAR, MEM_ADDR_SHIFT_IN, MEM_WRITE_PTR_ZERO;
  wire logic MEM_READ_PTR_ZERO, MEM_WRITE_PTR_ADVANCE, MEM_ADDR_ADVANCE, MEM_ADDR_LOAD_STROBE;
  wire logic MEM_WORD_LOAD_STROBE, MEM_WORD_REG_CLEAR, MEM_WORD_REG_ADVANCE, MEM_WORD_SHIFT;
  wire logic MEM_ACCESS_KIND_LEVEL, MEM_SAME_ADDR_UPDATE_LEVEL, MEM_CYCLE_DONE_PULSE;
  wire logic MEM_CYCLE_IN_PROGRESS_N, MEM_WORD_READY_PULSE, MEM_DIRECT_ADDR_FLAG;
  wire logic MEM_COUNTING_ADDR_FLAG, MEM_LOAD_MODE, MEM_UNLOAD_MODE;
  wire logic [ZONE_N-1:0] MEM_ZONE_MODE_LEVELS;
  wire logic [ADDR_W-1:0] MEM_ADDR_IN, MEM_ADDR_REG_OUTPUTS;
  wire logic [WORD_W-1:0] MEM_WORD_IN_T, MEM_WORD_IN_F;
  wire logic [WORD_W-1:0] MEM_WORD_REG_OUTPUTS_T, MEM_WORD_REG_OUTPUTS_F;
  // Pulse pins gathered by command code, so one loop can watch them all
  wire logic [NPULSE-1:0] pins = {MEM_WORD_SHIFT, MEM_WORD_REG_ADVANCE, MEM_WORD_REG_CLEAR,
    MEM_WORD_LOAD_STROBE, MEM_ADDR_LOAD_STROBE, MEM_ADDR_ADVANCE, MEM_WRITE_PTR_ADVANCE,
    MEM_READ_PTR_ZERO, MEM_WRITE_PTR_ZERO, MEM_ADDR_SHIFT_IN, MEM_ADDR_REG_CLEAR,
    MEM_CORE_WIPE_PULSE, MEM_UNLOAD_CMD, MEM_LOAD_CMD, MEM_OVERWRITE_CMD, MEM_REGEN_READ_CMD};
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  cmcp_host #(.ADDR_W(ADDR_W)) i_dut (.*);
  cmcp_mem_model #(.ADDR_W(ADDR_W)) i_mem (.*);
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    // Let the write settle so callers see the registered outputs
    #1;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Polls the busy bit; bounded so a stuck controller cannot hang the run
  task automatic idle();
    int i = 0;
    rd(OFF_STAT);
    while (d[ST_BUSY] !== 1'b0 && i < 500) begin
      rd(OFF_STAT);
      i++;
    end
    chk("busy", 48'h0, d[ST_BUSY]);
  endtask
  task automatic cmd(input logic [4:0] c);
    wr(OFF_CMD, {27'h0, c});
    idle();
  endtask
  task automatic t_reset();
    rd(OFF_CTRL);
    chk("ctrl", CTRL_RST, d[4:0]);
    chk("kind", 48'h1, MEM_ACCESS_KIND_LEVEL);
    chk("word_f", {WORD_W{1'b1}}, MEM_WORD_IN_F);
    chk("zones", 48'h0, MEM_ZONE_MODE_LEVELS);
    rd(6'h3C);
    chk("unmapped", 48'h0, d);
    rd(OFF_STAT);
    chk("flags", 48'h1, d[ST_FLAG_LSB+1:ST_FLAG_LSB]);
    $display("test reset done");
  endtask
  task automatic t_write_read();
    wr(OFF_ADDR, 32'h5A3);
    chk("addr_in", 48'h5A3, MEM_ADDR_IN);
    cmd(P_ASTROBE[4:0]);
    rd(OFF_AOUT);
    chk("aout", 48'h5A3, d[11:0]);
    wr(OFF_WLO, 32'h89AB_CDEF);
    wr(OFF_WHI, 32'h4567);
    chk("word_t", 48'h4567_89AB_CDEF, MEM_WORD_IN_T);
    chk("word_f", ~48'h4567_89AB_CDEF, MEM_WORD_IN_F);
    wr(OFF_CMD, P_OVERWRITE);
    n = 0;
    repeat (40) begin
      @(posedge CLK);
      #1;
      if (MEM_OVERWRITE_CMD === 1'b1) n++;
    end
    chk("pulse", PULSE_CYC, n);
    idle();
    wr(OFF_WLO, 32'h0);
    wr(OFF_WHI, 32'h0);
    cmd(P_REGEN[4:0]);
    rd(OFF_RLO);
    chk("rlo", 48'h89AB_CDEF, d);
    rd(OFF_RHI);
    chk("rhi", 48'h4567, d[15:0]);
    rd(OFF_STAT);
    chk("sticky", 48'h3, d[ST_STK_LSB+1:ST_STK_LSB]);
    $display("test write read done");
  endtask
  task automatic t_rmw();
    wr(OFF_CMD, {27'h0, CMD_RMW_UNLOAD});
    #1 chk("upd_on", 48'h1, MEM_SAME_ADDR_UPDATE_LEVEL);
    idle();
    rd(OFF_RLO);
    chk("rmw_old", 48'h89AB_CDEF, d);
    wr(OFF_WLO, 32'h1234_5678);
    cmd(CMD_RMW_LOAD);
    chk("upd_off", 48'h0, MEM_SAME_ADDR_UPDATE_LEVEL);
    rd(OFF_AOUT);
    chk("rmw_addr", 48'h5A3, d[11:0]);
    cmd(P_REGEN[4:0]);
    rd(OFF_RLO);
    chk("rmw_new", 48'h1234_5678, d);
    $display("test rmw done");
  endtask
  task automatic t_addr();
    cmd(P_ACLR[4:0]);
    rd(OFF_AOUT);
    chk("aclr", 48'h0, d[11:0]);
    cmd(P_AADV[4:0]);
    cmd(P_AADV[4:0]);
    rd(OFF_AOUT);
    chk("aadv", 48'h2, d[11:0]);
    $display("test address done");
  endtask
  task automatic t_refuse();
    wr(OFF_STAT, 32'h7C);
    cmd(CMD_RMW_LOAD);
    rd(OFF_STAT);
    chk("ref_load", 48'h1, d[ST_STK_LSB+STK_REFUSED]);
    wr(OFF_STAT, 32'h7C);
    wr(OFF_CMD, P_REGEN);
    wr(OFF_CMD, P_OVERWRITE);
    idle();
    rd(OFF_STAT);
    chk("ref_busy", 48'h1, d[ST_STK_LSB+STK_REFUSED]);
    $display("test refusal done");
  endtask
  task automatic t_levels();
    wr(OFF_CTRL, 32'h1E);
    chk("zones_on", 48'hF, MEM_ZONE_MODE_LEVELS);
    chk("kind_seq", 48'h0, MEM_ACCESS_KIND_LEVEL);
    // Flags come back through the synchroniser, two cycles late
    repeat (3) @(posedge CLK);
    rd(OFF_STAT);
    chk("flags_seq", 48'h2, d[ST_FLAG_LSB+1:ST_FLAG_LSB]);
    wr(OFF_CTRL, 32'(CTRL_RST));
    chk("kind_back", 48'h1, MEM_ACCESS_KIND_LEVEL);
    chk("zones_off", 48'h0, MEM_ZONE_MODE_LEVELS);
    $display("test levels done");
  endtask
  // Each single-pulse command must raise its own pin alone, for the set width
  task automatic t_pulses();
    int hi;
    int other;
    int w;
    for (int k = P_WIPE; k < NPULSE; k++) begin
      wr(OFF_CMD, 32'(k));
      hi = 0;
      other = 0;
      repeat (200) begin
        @(posedge CLK);
        #1;
        if (pins[k] === 1'b1) hi++;
        if ((pins & ~(NPULSE'(1) << k)) !== '0) other++;
      end
      idle();
      w = (k == P_WIPE) ? WIPE_CYC : PULSE_CYC;
      chk("pin_width", w, hi);
      chk("pin_other", 48'h0, other);
    end
    $display("test pulse pins done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 50000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    RST_N = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = '0;
    REG_WDATA = '0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_write_read();
    t_rmw();
    t_addr();
    t_refuse();
    t_levels();
    t_pulses();
    conclude();
  end
endmodule // cmcp_host_tb
